/* hw/dbg_regs_pkg.sv */
/*
  Constants, field layouts and carrier types for the debug status, transfer and breakpoint register block.
  Assumes a core-side coprocessor transfer port and a debugger-side scan port sampled on the processor clock.
*/
package dbg_regs_pkg;

  // ***************************************************************
  // Register numbers
  // ***************************************************************
  localparam logic [6:0] REG_STATUS     = 7'h01;
  localparam logic [6:0] REG_XFER       = 7'h05;
  localparam logic [2:0] OP2_BKPT_ADDR  = 3'h4;
  localparam logic [2:0] OP2_BKPT_CTL   = 3'h5;
  localparam int         NUM_BKPT       = 6;

  // ***************************************************************
  // Status field positions
  // ***************************************************************
  localparam int BIT_GLOBAL_ON   = 31;
  localparam int BIT_HALT_MODE   = 30;
  localparam int BIT_EXEC_SEL    = 29;
  localparam int BIT_INSN16      = 28;
  localparam int BIT_COMMS       = 27;
  localparam int BIT_CATCH_FIQ   = 23;
  localparam int BIT_CATCH_IRQ   = 22;
  localparam int BIT_CATCH_DABT  = 20;
  localparam int BIT_CATCH_PABT  = 19;
  localparam int BIT_CATCH_SWI   = 18;
  localparam int BIT_CATCH_UNDEF = 17;
  localparam int BIT_CATCH_RESET = 16;
  localparam int BIT_IN_FULL     = 7;
  localparam int BIT_OUT_EMPTY   = 6;
  localparam int BIT_ABORT       = 5;
  localparam int LSB_REASON      = 2;
  localparam int BIT_RESTARTED   = 1;
  localparam int BIT_HALTED      = 0;

  // Bits the debugger may write: 30..27, 23..22, 20..16.
  localparam logic [31:0] HOST_WR_MASK  = 32'h78DF0000;
  localparam logic [31:0] CORE_WR_MASK  = 32'h80000000;
  localparam logic [31:0] STATUS_RESET  = 32'h00000000;
  localparam logic [31:0] BKPT_RESET    = 32'h00000000;

  // ***************************************************************
  // Breakpoint control fields
  // ***************************************************************
  localparam int LSB_INSN_KIND  = 3;
  localparam int LSB_PRIV_MATCH = 1;
  localparam int BIT_BKPT_EN    = 0;

  // ***************************************************************
  // Entry reasons
  // ***************************************************************
  localparam logic [2:0] RSN_HALT_SCAN = 3'h0;
  localparam logic [2:0] RSN_BKPT      = 3'h1;
  localparam logic [2:0] RSN_WATCH     = 3'h2;
  localparam logic [2:0] RSN_BKPT_INSN = 3'h3;
  localparam logic [2:0] RSN_EXT_REQ   = 3'h4;
  localparam logic [2:0] RSN_VCATCH    = 3'h5;
  localparam logic [2:0] RSN_DABORT    = 3'h6;
  localparam logic [2:0] RSN_IABORT    = 3'h7;

  // Instruction-set codes of a fetch, one-hot as in the control field.
  localparam logic [2:0] ISET_BYTECODE = 3'h4;
  localparam logic [2:0] ISET_STD32    = 3'h2;
  localparam logic [2:0] ISET_COMP16   = 3'h1;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  op2;
    logic [3:0]  crm;
    logic [31:0] wdata;
  } coproc_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [2:0]  iset;
    logic        priv;
  } fetch_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] opcode;
    logic        compressed;
  } inject_t;

endpackage

/* hw/dbg_skid_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes producer and consumer on the same clock.
*/
`timescale 1ns/10ps
module dbg_skid_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [$clog2(DEPTH):0]      cnt;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   push;
  logic   pop;

  assign in_ready  = (s_q.cnt != ($clog2(DEPTH)+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[0];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (pop) begin
      for (int i = 0; i < DEPTH-1; i++) begin
        s_d.mem[i] = s_q.mem[i+1];
      end
    end
    if (push) begin
      s_d.mem[pop ? s_q.cnt - 1'b1 : s_q.cnt] = in_data;
    end
    s_d.cnt = s_q.cnt + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* hw/dbg_status_and_breakpoint_regs.sv */
/*
  Debug status/control, transfer and breakpoint registers of a processor core.
  Assumes the core drives one coprocessor transfer per cycle and the scan side arrives as unsynchronised pins with
  a scan clock sampled by sys_clk.
*/
`timescale 1ns/10ps
module dbg_status_and_breakpoint_regs #(
  parameter int NBKPT = dbg_regs_pkg::NUM_BKPT
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  // Core coprocessor port.
  input  wire dbg_regs_pkg::coproc_req_t core_req,
  output logic [31:0]                    core_rdata,
  output logic                           core_stall,
  // Core execution status.
  input  wire dbg_regs_pkg::fetch_t      fetch,
  input  wire logic                      core_abort,
  input  wire logic                      debug_enter,
  input  wire logic [2:0]                enter_reason,
  input  wire logic                      exit_start,
  input  wire logic                      exit_done,
  input  wire logic                      comms_active,
  output logic [NBKPT-1:0]               bkpt_hit,
  output logic [6:0]                     catch_vec,
  output logic                           global_dbg_on,
  output logic                           halt_mode,
  output dbg_regs_pkg::inject_t          inject,
  // Debugger scan port, asynchronous to sys_clk.
  input  wire logic                      scan_clk,
  input  wire logic                      scan_idle,
  input  wire logic                      scan_wr_status,
  input  wire logic                      scan_rd_status,
  input  wire logic                      scan_wr_data,
  input  wire logic                      scan_rd_data,
  input  wire logic                      scan_wr_opcode,
  input  wire logic [31:0]               scan_wdata,
  output logic [31:0]                    scan_rdata,
  output logic                           scan_in_busy,
  output logic                           scan_out_valid
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic [2:0] {
    RUN_NORMAL = 3'h1,
    RUN_HALTED = 3'h2,
    RUN_EXITING = 3'h4
  } run_t;

  typedef struct packed {
    logic [2:0]              clk_sync;
    logic [1:0]              idle_sync;
    logic [1:0]              wst_sync;
    logic [1:0]              rst_sync;
    logic [1:0]              wdt_sync;
    logic [1:0]              rdt_sync;
    logic [1:0]              wop_sync;
    logic [31:0]             wd_sync1;
    logic [31:0]             wd_sync2;
    logic                    idle_prev;
    logic                    global_on;
    logic [3:0]              host_ctl;
    logic [6:0]              catches;
    logic                    abort;
    logic [2:0]              reason;
    run_t                    run;
    logic                    restarted;
    logic                    in_full;
    logic [31:0]             in_buf;
    logic [31:0]             opcode;
    logic [31:0]             rdata;
    logic [31:0]             srdata;
    logic                    pend_in;
    logic [NBKPT-1:0][31:0]  baddr;
    logic [NBKPT-1:0][5:0]   bctl;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [31:0] status_word;
  logic [6:0]  reg_num;
  logic        scan_edge;
  logic        out_push;
  logic        out_ready;
  logic        out_valid;
  logic [31:0] out_data;
  logic        out_pop;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [6:0] reg_number(input logic [2:0] op2, input logic [3:0] crm);
    reg_number = {op2, crm};
  endfunction

  function automatic logic bkpt_match(input logic [31:0] a, input logic [5:0] c,
                                      input dbg_regs_pkg::fetch_t f, input logic on);
    logic iset_ok;
    logic priv_ok;
    iset_ok = |(c[dbg_regs_pkg::LSB_INSN_KIND +: 3] & f.iset);
    priv_ok = f.priv ? c[dbg_regs_pkg::LSB_PRIV_MATCH + 1] : c[dbg_regs_pkg::LSB_PRIV_MATCH];
    bkpt_match = on && f.valid && c[dbg_regs_pkg::BIT_BKPT_EN] && (f.addr == a) && iset_ok && priv_ok;
  endfunction

  // ***************************************************************
  // Outbound buffer
  // ***************************************************************
  // The core writes the outbound side; the debugger drains it, so a slow drain stalls the core.
  dbg_skid_buf #(
    .WIDTH (32),
    .DEPTH (2)
  ) u_out_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (out_push),
    .in_ready  (out_ready),
    .in_data   (core_req.wdata),
    .out_valid (out_valid),
    .out_ready (out_pop),
    .out_data  (out_data)
  );

  assign reg_num   = reg_number(core_req.op2, core_req.crm);
  assign out_push  = core_req.wr && (reg_num == dbg_regs_pkg::REG_XFER);
  assign core_stall = out_push && !out_ready;
  assign scan_edge = s_q.clk_sync[1] && !s_q.clk_sync[2];
  assign out_pop   = scan_edge && s_q.rdt_sync[1] && out_valid;

  // ***************************************************************
  // Status word
  // ***************************************************************
  always_comb begin
    status_word = dbg_regs_pkg::STATUS_RESET;
    status_word[dbg_regs_pkg::BIT_GLOBAL_ON] = s_q.global_on;
    status_word[dbg_regs_pkg::BIT_COMMS +: 3] = s_q.host_ctl[2:0];
    status_word[dbg_regs_pkg::BIT_HALT_MODE] = s_q.host_ctl[3];
    status_word[dbg_regs_pkg::BIT_COMMS] = comms_active;
    status_word[dbg_regs_pkg::BIT_CATCH_FIQ] = s_q.catches[6];
    status_word[dbg_regs_pkg::BIT_CATCH_IRQ] = s_q.catches[5];
    status_word[dbg_regs_pkg::BIT_CATCH_DABT] = s_q.catches[4];
    status_word[dbg_regs_pkg::BIT_CATCH_PABT] = s_q.catches[3];
    status_word[dbg_regs_pkg::BIT_CATCH_SWI] = s_q.catches[2];
    status_word[dbg_regs_pkg::BIT_CATCH_UNDEF] = s_q.catches[1];
    status_word[dbg_regs_pkg::BIT_CATCH_RESET] = s_q.catches[0];
    status_word[dbg_regs_pkg::BIT_IN_FULL] = s_q.in_full;
    status_word[dbg_regs_pkg::BIT_OUT_EMPTY] = out_ready;
    status_word[dbg_regs_pkg::BIT_ABORT] = s_q.abort;
    status_word[dbg_regs_pkg::LSB_REASON +: 3] = s_q.reason;
    status_word[dbg_regs_pkg::BIT_RESTARTED] = s_q.restarted;
    status_word[dbg_regs_pkg::BIT_HALTED] = (s_q.run == RUN_HALTED);
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    logic [31:0] cw;
    logic [31:0] hw;
    cw = '0;
    hw = '0;
    s_d = s_q;
    s_d.clk_sync  = {s_q.clk_sync[1:0], scan_clk};
    s_d.idle_sync = {s_q.idle_sync[0], scan_idle};
    s_d.wst_sync  = {s_q.wst_sync[0], scan_wr_status};
    s_d.rst_sync  = {s_q.rst_sync[0], scan_rd_status};
    s_d.wdt_sync  = {s_q.wdt_sync[0], scan_wr_data};
    s_d.rdt_sync  = {s_q.rdt_sync[0], scan_rd_data};
    s_d.wop_sync  = {s_q.wop_sync[0], scan_wr_opcode};
    s_d.wd_sync1  = scan_wdata;
    s_d.wd_sync2  = s_q.wd_sync1;
    s_d.idle_prev = s_q.idle_sync[1];
    s_d.rdata     = s_q.rdata;

    // Core register transfers.
    if (core_req.rd) begin
      s_d.rdata = '0;
      if (reg_num == dbg_regs_pkg::REG_STATUS) begin
        // Core sees enable, buffer flags, reason and catches; other bits read as zero.
        s_d.rdata = status_word & 32'h80DF00DC;
      end else if (reg_num == dbg_regs_pkg::REG_XFER) begin
        s_d.rdata = s_q.in_buf;
        s_d.in_full = 1'b0;
      end else if (core_req.op2 == dbg_regs_pkg::OP2_BKPT_ADDR && core_req.crm < 4'(NBKPT)) begin
        s_d.rdata = s_q.baddr[core_req.crm];
      end else if (core_req.op2 == dbg_regs_pkg::OP2_BKPT_CTL && core_req.crm < 4'(NBKPT)) begin
        s_d.rdata = {26'h0, s_q.bctl[core_req.crm]};
      end
    end
    if (core_req.wr) begin
      if (reg_num == dbg_regs_pkg::REG_STATUS) begin
        cw = core_req.wdata & dbg_regs_pkg::CORE_WR_MASK;
        s_d.global_on = cw[dbg_regs_pkg::BIT_GLOBAL_ON];
      end else if (core_req.op2 == dbg_regs_pkg::OP2_BKPT_ADDR && core_req.crm < 4'(NBKPT)) begin
        s_d.baddr[core_req.crm] = core_req.wdata;
      end else if (core_req.op2 == dbg_regs_pkg::OP2_BKPT_CTL && core_req.crm < 4'(NBKPT)) begin
        s_d.bctl[core_req.crm] = core_req.wdata[5:0];
      end
    end

    // Debugger accesses act on the sampled scan clock rising edge.
    if (scan_edge) begin
      if (s_q.wst_sync[1]) begin
        hw = s_q.wd_sync2 & dbg_regs_pkg::HOST_WR_MASK;
        s_d.host_ctl = {hw[dbg_regs_pkg::BIT_HALT_MODE], hw[dbg_regs_pkg::BIT_EXEC_SEL],
                        hw[dbg_regs_pkg::BIT_INSN16], hw[dbg_regs_pkg::BIT_COMMS]};
        s_d.catches  = {hw[23:22], hw[20:16]};
      end
      if (s_q.rst_sync[1]) begin
        s_d.srdata = status_word;
        s_d.abort  = 1'b0;
      end
      if (s_q.wdt_sync[1] && !s_q.in_full) begin
        s_d.in_buf  = s_q.wd_sync2;
        s_d.in_full = 1'b1;
      end
      if (s_q.rdt_sync[1]) begin
        s_d.srdata = out_data;
      end
      if (s_q.wop_sync[1]) begin
        s_d.opcode = s_q.wd_sync2;
      end
    end
    if (core_abort) begin
      s_d.abort = 1'b1;
    end

    // Run state tracking.
    case (s_q.run)
      RUN_NORMAL: begin
        if (debug_enter && s_q.global_on) begin
          s_d.run       = RUN_HALTED;
          s_d.reason    = enter_reason;
          s_d.restarted = 1'b0;
        end
      end
      RUN_HALTED: begin
        if (exit_start) begin
          s_d.run = RUN_EXITING;
        end
      end
      RUN_EXITING: begin
        if (exit_done) begin
          s_d.run       = RUN_NORMAL;
          s_d.restarted = 1'b1;
        end
      end
      default: begin
        s_d.run = RUN_NORMAL;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.run       <= RUN_NORMAL;
      s_q.restarted <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  always_comb begin
    for (int i = 0; i < NBKPT; i++) begin
      bkpt_hit[i] = bkpt_match(s_q.baddr[i], s_q.bctl[i], fetch, s_q.global_on);
    end
  end

  // Catch bits drive the core's exception vector breakpoints when debug is on.
  assign catch_vec      = s_q.global_on ? s_q.catches : 7'h00;
  assign global_dbg_on  = s_q.global_on;
  assign halt_mode      = s_q.host_ctl[3];
  assign inject.valid   = s_q.host_ctl[2] && s_q.idle_sync[1] && !s_q.idle_prev;
  assign inject.opcode  = s_q.host_ctl[1] ? {16'h0000, s_q.opcode[15:0]} : s_q.opcode;
  assign inject.compressed = s_q.host_ctl[1];
  assign core_rdata     = s_q.rdata;
  assign scan_rdata     = s_q.srdata;
  assign scan_in_busy   = s_q.in_full;
  assign scan_out_valid = out_valid;

endmodule

/* test/dbg_regs_monitor.sv */
/*
  Port checker for the debug status, transfer and breakpoint register block.
  Assumes it is bound to the block's top module and sees only its ports.
*/
`timescale 1ns/10ps
module dbg_regs_monitor #(
  parameter int NBKPT = 6
) (
  input wire logic                      sys_clk,
  input wire logic                      rst_n,
  input wire dbg_regs_pkg::coproc_req_t core_req,
  input wire logic [31:0]               core_rdata,
  input wire logic                      core_stall,
  input wire dbg_regs_pkg::fetch_t      fetch,
  input wire logic                      debug_enter,
  input wire logic [2:0]                enter_reason,
  input wire logic [NBKPT-1:0]          bkpt_hit,
  input wire logic [6:0]                catch_vec,
  input wire logic                      global_dbg_on,
  input wire logic                      halt_mode,
  input wire dbg_regs_pkg::inject_t     inject,
  input wire logic                      scan_wr_status,
  input wire logic                      scan_in_busy,
  input wire logic                      scan_out_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic sel_stat = {core_req.op2, core_req.crm} == 7'h01;
  wire logic sel_xfer = {core_req.op2, core_req.crm} == 7'h05;
  // An entry is followed at once by a core read of the status register.
  sequence s_enter;
    debug_enter && global_dbg_on ##1 core_req.rd && sel_stat;
  endsequence
  chk_stat_core_view: assert property (core_req.rd && sel_stat |=>
    core_rdata[31] == $past(global_dbg_on) && core_rdata[30:27] == 4'h0) else $error("core status view wrong");
  chk_core_ge_wr: assert property (core_req.wr && sel_stat |=>
    global_dbg_on == $past(core_req.wdata[31])) else $error("global enable not written");
  chk_halt_scan_only: assert property ((!scan_wr_status)[*8] |=> $stable(halt_mode))
    else $error("halt mode changed without scan write");
  chk_catch_gated: assert property (!global_dbg_on |-> catch_vec == 7'h00)
    else $error("catch active while debug off");
  chk_hit_gated: assert property (!(global_dbg_on && fetch.valid) |-> bkpt_hit == '0)
    else $error("hit without enabled fetch");
  chk_stall_cause: assert property (core_stall |-> core_req.wr && sel_xfer && scan_out_valid)
    else $error("stall without full outbound write");
  chk_out_fill: assert property (core_req.wr && sel_xfer && !core_stall |=> scan_out_valid)
    else $error("outbound word lost");
  chk_in_clear: assert property (core_req.rd && sel_xfer && scan_in_busy |=> !scan_in_busy)
    else $error("inbound full not cleared by read");
  chk_entry_reason: assert property (s_enter |=> core_rdata[4:2] == $past(enter_reason, 2))
    else $error("entry reason not recorded");
  chk_inject_pulse: assert property (inject.valid |=> !inject.valid)
    else $error("inject longer than one cycle");
endmodule
bind dbg_status_and_breakpoint_regs dbg_regs_monitor #(.NBKPT(NBKPT)) u_dbg_regs_monitor (.sys_clk, .rst_n,
  .core_req, .core_rdata, .core_stall, .fetch, .debug_enter, .enter_reason, .bkpt_hit, .catch_vec,
  .global_dbg_on, .halt_mode, .inject, .scan_wr_status, .scan_in_busy, .scan_out_valid);

/* test/dbg_scan_model.sv */
/*
  Behavioural model of the external debugger driving the scan pins.
  Assumes the bench calls frame from one process at a time.
*/
`timescale 1ns/10ps
module dbg_scan_model (
  output logic              scan_clk,
  output logic              scan_idle,
  output logic              scan_wr_status,
  output logic              scan_rd_status,
  output logic              scan_wr_data,
  output logic              scan_rd_data,
  output logic              scan_wr_opcode,
  output logic [31:0]       scan_wdata,
  input  wire logic [31:0]  scan_rdata,
  input  wire logic         scan_in_busy
);
  logic [5:0] act;
  assign {scan_idle, scan_wr_opcode, scan_rd_data, scan_wr_data, scan_rd_status, scan_wr_status} = act;
  initial begin
    scan_clk = 1'b0;
    act = 6'h00;
    scan_wdata = 32'h0;
  end
  // One frame of one link clock period; the clock stands still between frames and released data is inverted.
  task automatic frame(input logic [5:0] a, input logic [31:0] d, output logic [31:0] q, output logic to);
    int n;
    n = 0;
    while (a[2] && scan_in_busy && n < 50) begin
      #80;
      n++;
    end
    to = (n == 50);
    act = a;
    scan_wdata = d;
    #40 scan_clk = 1'b1;
    #40 scan_clk = 1'b0;
    #40 q = scan_rdata;
    act = 6'h00;
    scan_wdata = ~d;
  endtask
endmodule

/* test/dbg_status_and_breakpoint_regs_tb.sv */
/*
  Testbench for the debug register block, driving the core port and a scan debugger model.
  Assumes the checker is bound to the block and the model sits on the scan pins.
*/
`timescale 1ns/10ps
module dbg_status_and_breakpoint_regs_tb;
  logic                      sys_clk, rst_n, core_stall, core_abort, debug_enter, exit_start, exit_done;
  logic                      comms_active, global_dbg_on, halt_mode, st, scan_in_busy, scan_out_valid;
  logic                      scan_clk, scan_idle, scan_wr_status, scan_rd_status, scan_wr_data;
  logic                      scan_rd_data, scan_wr_opcode;
  logic [31:0]               core_rdata, scan_wdata, scan_rdata, q;
  logic [2:0]                enter_reason;
  logic [5:0]                bkpt_hit;
  logic [6:0]                catch_vec;
  dbg_regs_pkg::coproc_req_t core_req;
  dbg_regs_pkg::fetch_t      fetch;
  dbg_regs_pkg::inject_t     inject, inj_q;
  int                        fails = 0, checks_done = 0, inj_cnt = 0;
  int                        cpos[7] = '{23, 22, 20, 19, 18, 17, 16};
  logic [5:0]                tv[4] = '{6'b1_010_1_0, 6'b1_001_0_0, 6'b1_001_1_1, 6'b0_001_1_0};
  dbg_status_and_breakpoint_regs u_dbg_status_and_breakpoint_regs (.sys_clk, .rst_n, .core_req, .core_rdata,
    .core_stall, .fetch, .core_abort, .debug_enter, .enter_reason, .exit_start, .exit_done, .comms_active,
    .bkpt_hit, .catch_vec, .global_dbg_on, .halt_mode, .inject, .scan_clk, .scan_idle, .scan_wr_status,
    .scan_rd_status, .scan_wr_data, .scan_rd_data, .scan_wr_opcode, .scan_wdata, .scan_rdata, .scan_in_busy,
    .scan_out_valid);
  dbg_scan_model u_dbg_scan_model (.scan_clk, .scan_idle, .scan_wr_status, .scan_rd_status, .scan_wr_data,
    .scan_rd_data, .scan_wr_opcode, .scan_wdata, .scan_rdata, .scan_in_busy);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (inject.valid) begin
      inj_cnt <= inj_cnt + 1;
      inj_q <= inject;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One core transfer to register number r; the stall level is kept for the caller.
  task automatic cacc(input logic w, input logic [6:0] r, input logic [31:0] d);
    core_req <= {~w, w, r[6:4], r[3:0], d};
    @(negedge sys_clk) st = core_stall;
    @(posedge sys_clk) core_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic crd(input logic [6:0] r, input logic [31:0] e);
    cacc(1'b0, r, 32'h0);
    chk(core_rdata, e);
  endtask
  task automatic sc(input logic [5:0] a, input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
    logic to;
    u_dbg_scan_model.frame(a, d, q, to);
    @(posedge sys_clk);
    if (to) fails++;
    if (m != 32'h0) chk(q & m, e);
  endtask
  task automatic ev(input logic [3:0] k);
    {core_abort, exit_done, exit_start, debug_enter} <= k;
    @(posedge sys_clk) {core_abort, exit_done, exit_start, debug_enter} <= 4'h0;
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    finish_test();
  end
  initial begin
    {rst_n, core_abort, debug_enter, exit_start, exit_done, comms_active} = 6'h00;
    core_req = '0;
    fetch = '0;
    enter_reason = 3'h0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    crd(7'h01, 32'h00000040);
    sc(6'h02, 32'h0, 32'h00000042, 32'hFFFFFFFF);
    crd(7'h50, 32'h0);
    cacc(1'b1, 7'h01, 32'hFFFFFFFF);
    crd(7'h01, 32'h80000040);
    chk(32'(halt_mode), 32'h0);
    sc(6'h01, 32'h77FF0000, 32'h0, 32'h0);
    sc(6'h02, 32'h0, 32'hF0DF0042, 32'hFFFFFFFF);
    chk(32'(halt_mode), 32'h1);
    foreach (cpos[k]) begin
      sc(6'h01, 32'h70000000 | (32'h1 << cpos[k]), 32'h0, 32'h0);
      chk(32'(catch_vec), 32'h40 >> k);
    end
    cacc(1'b1, 7'h01, 32'h0);
    chk(32'(catch_vec), 32'h0);
    ev(4'h1);
    sc(6'h02, 32'h0, 32'h0, 32'h1);
    cacc(1'b1, 7'h01, 32'h80000000);
    sc(6'h01, 32'h70000000, 32'h0, 32'h0);
    ev(4'h8);
    sc(6'h02, 32'h0, 32'h20, 32'h20);
    sc(6'h02, 32'h0, 32'h0, 32'h20);
    comms_active <= 1'b1;
    sc(6'h02, 32'h0, 32'h08000000, 32'h08000000);
    comms_active <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      enter_reason <= 3'(r);
      ev(4'h1);
      crd(7'h01, 32'h80000040 | (32'(r) << 2));
      sc(6'h02, 32'h0, 32'h1, 32'h3);
      ev(4'h2);
      @(posedge sys_clk);
      ev(4'h4);
      sc(6'h02, 32'h0, 32'h2, 32'h3);
    end
    sc(6'h10, 32'h1234ABCD, 32'h0, 32'h0);
    sc(6'h20, 32'h0, 32'h0, 32'h0);
    chk(32'(inj_cnt), 32'h1);
    chk({inj_q.opcode[30:0], inj_q.compressed}, 32'h0001579B);
    sc(6'h01, 32'h0, 32'h0, 32'h0);
    sc(6'h20, 32'h0, 32'h0, 32'h0);
    chk(32'(inj_cnt), 32'h1);
    sc(6'h04, 32'hA5A50001, 32'h0, 32'h0);
    chk(32'(scan_in_busy), 32'h1);
    crd(7'h01, 32'h800000DC);
    crd(7'h05, 32'hA5A50001);
    chk(32'(scan_in_busy), 32'h0);
    for (int k = 0; k < 3; k++) begin
      cacc(1'b1, 7'h05, 32'hC0DE0000 + 32'(k));
      chk(32'(st), 32'(k == 2));
    end
    crd(7'h01, 32'h8000001C);
    sc(6'h08, 32'h0, 32'hC0DE0000, 32'hFFFFFFFF);
    sc(6'h08, 32'h0, 32'hC0DE0001, 32'hFFFFFFFF);
    chk(32'(scan_out_valid), 32'h0);
    crd(7'h01, 32'h8000005C);
    for (int k = 0; k < 6; k++) begin
      cacc(1'b1, 7'h40 + 7'(k), 32'h1000 + 32'(k) * 16);
      cacc(1'b1, 7'h50 + 7'(k), 32'h3F);
    end
    for (int k = 0; k < 6; k++) begin
      crd(7'h40 + 7'(k), 32'h1000 + 32'(k) * 16);
      crd(7'h50 + 7'(k), 32'h3F);
      fetch <= {1'b1, 32'h1000 + 32'(k) * 16, 3'h2, 1'b1};
      @(negedge sys_clk) chk(32'(bkpt_hit), 32'h1 << k);
      @(posedge sys_clk);
    end
    foreach (tv[k]) begin
      cacc(1'b1, 7'h52, {26'h0, 5'b00110, tv[k][5]});
      fetch <= {1'b1, 32'h1020, tv[k][4:2], tv[k][1]};
      @(negedge sys_clk) chk(32'(bkpt_hit), 32'(tv[k][0]) << 2);
      @(posedge sys_clk);
    end
    cacc(1'b1, 7'h30, 32'hFFFFFFFF);
    crd(7'h30, 32'h0);
    crd(7'h46, 32'h0);
    fetch <= '0;
    @(posedge sys_clk);
    finish_test();
  end
endmodule
